// ### timer16_defines.svh
/*
  Offsets, field positions, reset values and counts for the 16-bit timer.
  Assumes byte addresses on a 32-bit AXI4-Lite bus, one 8-bit register per word.
*/
// Notes on behaviour
// - Wide values reached as two byte accesses.
// - One high-byte staging latch shared per timer.
// - Low-byte write loads staged high byte together.
// - Counter or capture low-byte read copies high byte into latch.
// - Compare reads bypass latch, latch unchanged.
// - Control registers are plain, any order.
// - Tick from prescaler or edge-selected pin.
// - Both buffered compares checked on every timer tick but the first after a counter write.
// - Match drives wave output and sets flag.
// - Capture edge copies counter into capture register unless that register is the ceiling.
// - Selectable noise filter before capture edge detect.
// - Ceiling fixed, compare A or capture register.
// - Compare-A ceiling: no PWM A, ceiling buffered in PWM modes only.
// - Capture-register ceiling leaves PWM A usable.
// - Counter zero is the bottom condition.
// - Counter 0xFFFF is the maximum condition.
// - Four flags, each individually maskable.
// - High-byte writes, and counter or capture high reads, access the staging latch.
// - Counter write beats count or clear.
// - Capture flag set with the capture copy.
// - Select zero stops counting, access still works.
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

`define OFF_CTL_A     8'h00
`define OFF_CTL_B     8'h04
`define OFF_COUNT_LO  8'h08
`define OFF_COUNT_HI  8'h0c
`define OFF_CMPA_LO   8'h10
`define OFF_CMPA_HI   8'h14
`define OFF_CMPB_LO   8'h18
`define OFF_CMPB_HI   8'h1c
`define OFF_CAP_LO    8'h20
`define OFF_CAP_HI    8'h24
`define OFF_FLAGS     8'h28
`define OFF_MASK      8'h2c
`define OFF_CAP_SRC   8'h30

// timer_control_a
`define CTLA_COM_A    7:6
`define CTLA_COM_B    5:4
`define CTLA_WGM_LO   1:0
// timer_control_b
`define CTLB_FILT_EN  7
`define CTLB_EDGE     6
`define CTLB_WGM_HI   4:3
`define CTLB_CS       2:0
// timer_flag_reg / timer_mask_reg
`define FLG_OVF       0
`define FLG_MATCH_A   1
`define FLG_MATCH_B   2
`define FLG_CAPTURE   3

`define RST_BYTE      8'h00
`define RST_WORD      16'h0000
`define CNT_BOTTOM    16'h0000
`define CNT_MAX       16'hffff
`define TOP_8BIT      16'h00ff
`define TOP_9BIT      16'h01ff
`define TOP_10BIT     16'h03ff

`define CS_STOP       3'h0
`define CS_DIV1       3'h1
`define CS_DIV8       3'h2
`define CS_DIV64      3'h3
`define CS_DIV256     3'h4
`define CS_DIV1024    3'h5
`define CS_EXT_FALL   3'h6
`define CS_EXT_RISE   3'h7
`define PRESCALE_W    10

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ### timer16_pkg.sv
/*
  Types for the 16-bit timer: ceiling kinds and the state records.
  Assumes timer16_defines.svh is compiled alongside.
*/
package timer16_pkg;

  typedef enum logic [5:0] {
    TOP_MAX  = 6'b000001,
    TOP_FF   = 6'b000010,
    TOP_1FF  = 6'b000100,
    TOP_3FF  = 6'b001000,
    TOP_OCRA = 6'b010000,
    TOP_ICR  = 6'b100000
  } top_kind_t;

  typedef struct packed {
    logic [9:0] pre;
    logic       ext_prev;
    logic       tick;
  } tick_state_t;

  typedef struct packed {
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       waddr_ok;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic       wen;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [15:0] count;
    logic       block;
    logic [7:0] temp;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [15:0] cmpa_buf;
    logic [15:0] cmpb_buf;
    logic [15:0] cap;
    logic [3:0] flags;
    logic [3:0] mask;
    logic [3:0] irq;
    logic       cap_src;
    logic [7:0] filt;
    logic       level;
    logic       wave_a;
    logic       wave_b;
  } timer_state_t;

endpackage

// ### tick_gen.sv
/*
  Timer tick source: free-running prescaler and external pin edge detector.
  Assumes ext_pin is already synchronous to clk.
*/
`timescale 1ns/1ps
`include "timer16_defines.svh"

module tick_gen
  import timer16_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] clock_source_select,
  input  wire logic       ext_count_pin,
  output logic            timer_tick
);

  tick_state_t s_r;
  tick_state_t s_nxt;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.pre      = s_r.pre + 10'h001;
    s_nxt.ext_prev = ext_count_pin;
    case (clock_source_select)
      `CS_DIV1:     s_nxt.tick = 1'b1;
      `CS_DIV8:     s_nxt.tick = &s_r.pre[2:0];
      `CS_DIV64:    s_nxt.tick = &s_r.pre[5:0];
      `CS_DIV256:   s_nxt.tick = &s_r.pre[7:0];
      `CS_DIV1024:  s_nxt.tick = &s_r.pre[9:0];
      `CS_EXT_FALL: s_nxt.tick = s_r.ext_prev & ~ext_count_pin;
      `CS_EXT_RISE: s_nxt.tick = ~s_r.ext_prev & ext_count_pin;
      default:      s_nxt.tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign timer_tick = s_r.tick;

endmodule

// ### timer16_core.sv
/*
  16-bit timer/counter with two buffered compares, filtered input capture,
  shared high-byte staging latch and an AXI4-Lite register slave.
  Assumes all pins are synchronous to CORE_CLK; one write and one read at once.
*/
`timescale 1ns/1ps
`include "timer16_defines.svh"

module timer16_core
  import timer16_pkg::*;
#(
  parameter int ADDR_W     = 8,
  parameter int FILTER_LEN = 4
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic [2:0]        S_AXI_AWPROT,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic [2:0]        S_AXI_ARPROT,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic              EXT_COUNT_PIN,
  input  wire logic              CAPTURE_PIN,
  input  wire logic              COMPARATOR_OUTPUT,
  output logic                   WAVE_OUT_A,
  output logic                   WAVE_OUT_B,
  output logic [3:0]             IRQ_REQ
);

  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8");
    end
    if (FILTER_LEN < 2 || FILTER_LEN > 8) begin : g_bad_filt
      $error("FILTER_LEN must lie in 2..8");
    end
  endgenerate

  timer_state_t s_r;
  timer_state_t s_nxt;
  logic         tick;

  function automatic top_kind_t top_kind(input logic [3:0] wgm);
    case (wgm)
      4'h1, 4'h5:        top_kind = TOP_FF;
      4'h2, 4'h6:        top_kind = TOP_1FF;
      4'h3, 4'h7:        top_kind = TOP_3FF;
      4'h4, 4'h9, 4'hb,
      4'hf:              top_kind = TOP_OCRA;
      4'h8, 4'ha, 4'hc,
      4'he:              top_kind = TOP_ICR;
      default:           top_kind = TOP_MAX;
    endcase
  endfunction

  // Counting here is single-slope; PWM modes differ in compare update, wave output and overflow flag
  function automatic logic is_pwm(input logic [3:0] wgm);
    is_pwm = !(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hc || wgm == 4'hd);
  endfunction

  function automatic logic [15:0] top_value(input top_kind_t k,
                                            input logic [15:0] ocra,
                                            input logic [15:0] icr);
    case (k)
      TOP_FF:   top_value = `TOP_8BIT;
      TOP_1FF:  top_value = `TOP_9BIT;
      TOP_3FF:  top_value = `TOP_10BIT;
      TOP_OCRA: top_value = ocra;
      TOP_ICR:  top_value = icr;
      default:  top_value = `CNT_MAX;
    endcase
  endfunction

  function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                     input logic pwm, input logic bottom,
                                     input logic match);
    wave_next = cur;
    if (pwm) begin
      if (bottom && com[1]) begin
        wave_next = ~com[0];
      end
      if (match && com[1]) begin
        wave_next = com[0];
      end
    end else if (match) begin
      case (com)
        2'h1:    wave_next = ~cur;
        2'h2:    wave_next = 1'b0;
        2'h3:    wave_next = 1'b1;
        default: wave_next = cur;
      endcase
    end
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'h0) && (a <= `OFF_CAP_SRC);
  endfunction

  function automatic logic filt_stable(input logic [7:0] f, input int len);
    logic ones;
    logic zeros;
    ones  = 1'b1;
    zeros = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i < len) begin
        ones  = ones & f[i];
        zeros = zeros & ~f[i];
      end
    end
    filt_stable = ones | zeros;
  endfunction

  tick_gen u_tick (
    .clk                 (CORE_CLK),
    .rst                 (RST),
    .clock_source_select (s_r.ctl_b[`CTLB_CS]),
    .ext_count_pin       (EXT_COUNT_PIN),
    .timer_tick          (tick)
  );

  always_comb begin
    logic [3:0]  wgm;
    top_kind_t   kind;
    logic        pwm;
    logic [15:0] top;
    logic        at_top;
    logic        match_a;
    logic        match_b;
    logic        do_wr;
    logic        wr;
    logic        rd;
    logic [7:0]  ra;
    logic [3:0]  set;
    logic [3:0]  clr;
    logic        new_level;
    wgm       = {s_r.ctl_b[`CTLB_WGM_HI], s_r.ctl_a[`CTLA_WGM_LO]};
    kind      = top_kind(wgm);
    pwm       = is_pwm(wgm);
    top       = top_value(kind, s_r.cmpa, s_r.cap);
    at_top    = s_r.count == top;
    s_nxt     = s_r;
    set       = 4'h0;
    clr       = 4'h0;
    match_a   = 1'b0;
    match_b   = 1'b0;
    do_wr     = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    new_level = s_r.level;
    ra        = S_AXI_ARADDR[7:0];

    // Write channel: address and data taken in either order
    if (S_AXI_AWVALID && s_r.awready) begin
      s_nxt.awready  = 1'b0;
      s_nxt.waddr    = S_AXI_AWADDR[7:0];
      s_nxt.waddr_ok = (S_AXI_AWADDR >> 8) == '0;
    end
    if (S_AXI_WVALID && s_r.wready) begin
      s_nxt.wready = 1'b0;
      s_nxt.wdata  = S_AXI_WDATA[7:0];
      s_nxt.wen    = S_AXI_WSTRB[0];
    end
    do_wr = !s_r.awready && !s_r.wready && !s_r.bvalid;
    wr    = do_wr && s_r.wen && s_r.waddr_ok && addr_mapped(s_r.waddr);
    if (do_wr) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = (s_r.waddr_ok && addr_mapped(s_r.waddr)) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end

    // Compare is checked on each tick; a counter write masks the next tick's match
    match_a = tick && !s_r.block && s_r.count == s_r.cmpa;
    match_b = tick && !s_r.block && s_r.count == s_r.cmpb;

    if (tick) begin
      s_nxt.block = 1'b0;
      s_nxt.count = at_top ? `CNT_BOTTOM : s_r.count + 16'h0001;
      if (pwm && at_top) begin
        s_nxt.cmpa = s_r.cmpa_buf;
        s_nxt.cmpb = s_r.cmpb_buf;
      end
    end
    if (pwm) begin
      set[`FLG_OVF] = tick && at_top;
    end else begin
      set[`FLG_OVF] = tick && s_r.count == `CNT_MAX;
    end
    set[`FLG_MATCH_A] = match_a;
    set[`FLG_MATCH_B] = match_b;

    // Compare-A as PWM ceiling cannot also shape channel A
    if (!(pwm && kind == TOP_OCRA)) begin
      s_nxt.wave_a = wave_next(s_r.wave_a, s_r.ctl_a[`CTLA_COM_A], pwm,
                               tick && at_top, match_a);
    end
    s_nxt.wave_b = wave_next(s_r.wave_b, s_r.ctl_a[`CTLA_COM_B], pwm,
                             tick && at_top, match_b);

    // Capture: optional filter, then edge select
    s_nxt.filt = {s_r.filt[6:0], s_r.cap_src ? COMPARATOR_OUTPUT : CAPTURE_PIN};
    if (s_r.ctl_b[`CTLB_FILT_EN]) begin
      new_level = filt_stable(s_r.filt, FILTER_LEN) ? s_r.filt[0] : s_r.level;
    end else begin
      new_level = s_r.filt[0];
    end
    s_nxt.level = new_level;
    // Capture register is the ceiling in those modes, so it stops sampling
    if (kind != TOP_ICR && new_level != s_r.level
        && new_level == s_r.ctl_b[`CTLB_EDGE]) begin
      s_nxt.cap          = s_r.count;
      set[`FLG_CAPTURE]  = 1'b1;
    end

    // Register writes; the staging latch serves every wide register
    if (wr) begin
      case (s_r.waddr)
        `OFF_CTL_A:   s_nxt.ctl_a = s_r.wdata;
        `OFF_CTL_B:   s_nxt.ctl_b = s_r.wdata;
        `OFF_COUNT_LO: begin
          s_nxt.count = {s_r.temp, s_r.wdata};
          s_nxt.block = 1'b1;
        end
        `OFF_CMPA_LO: begin
          s_nxt.cmpa_buf = {s_r.temp, s_r.wdata};
          if (!pwm) begin
            s_nxt.cmpa = {s_r.temp, s_r.wdata};
          end
        end
        `OFF_CMPB_LO: begin
          s_nxt.cmpb_buf = {s_r.temp, s_r.wdata};
          if (!pwm) begin
            s_nxt.cmpb = {s_r.temp, s_r.wdata};
          end
        end
        `OFF_CAP_LO: begin
          if (kind == TOP_ICR) begin
            s_nxt.cap = {s_r.temp, s_r.wdata};
          end
        end
        `OFF_COUNT_HI, `OFF_CMPA_HI,
        `OFF_CMPB_HI, `OFF_CAP_HI: s_nxt.temp = s_r.wdata;
        `OFF_FLAGS:   clr = s_r.wdata[3:0];
        `OFF_MASK:    s_nxt.mask = s_r.wdata[3:0];
        `OFF_CAP_SRC: s_nxt.cap_src = s_r.wdata[0];
        default:      s_nxt.mask = s_r.mask;
      endcase
    end

    // Hardware set wins over a same-cycle write-one clear
    s_nxt.flags = (s_r.flags & ~clr) | set;
    s_nxt.irq   = s_r.flags & s_r.mask;

    // Read channel: data and latch side effect fixed at the address handshake
    rd = S_AXI_ARVALID && s_r.arready && ((S_AXI_ARADDR >> 8) == '0);
    if (S_AXI_ARVALID && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rresp   = (rd && addr_mapped(ra)) ? `RESP_OKAY : `RESP_SLVERR;
      s_nxt.rdata   = `RST_BYTE;
      if (rd) begin
        case (ra)
          `OFF_CTL_A:    s_nxt.rdata = s_r.ctl_a;
          `OFF_CTL_B:    s_nxt.rdata = s_r.ctl_b;
          `OFF_COUNT_LO: begin
            s_nxt.rdata = s_r.count[7:0];
            s_nxt.temp  = s_r.count[15:8];
          end
          `OFF_CMPA_LO:  s_nxt.rdata = s_r.cmpa_buf[7:0];
          `OFF_CMPA_HI:  s_nxt.rdata = s_r.cmpa_buf[15:8];
          `OFF_CMPB_LO:  s_nxt.rdata = s_r.cmpb_buf[7:0];
          `OFF_CMPB_HI:  s_nxt.rdata = s_r.cmpb_buf[15:8];
          `OFF_CAP_LO:   begin
            s_nxt.rdata = s_r.cap[7:0];
            s_nxt.temp  = s_r.cap[15:8];
          end
          `OFF_COUNT_HI, `OFF_CAP_HI: s_nxt.rdata = s_r.temp;
          `OFF_FLAGS:    s_nxt.rdata = {4'h0, s_r.flags};
          `OFF_MASK:     s_nxt.rdata = {4'h0, s_r.mask};
          `OFF_CAP_SRC:  s_nxt.rdata = {7'h00, s_r.cap_src};
          default:       s_nxt.rdata = `RST_BYTE;
        endcase
      end
    end
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s_r         <= '0;
      s_r.awready <= 1'b1;
      s_r.wready  <= 1'b1;
      s_r.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign S_AXI_AWREADY = s_r.awready;
  assign S_AXI_WREADY  = s_r.wready;
  assign S_AXI_BVALID  = s_r.bvalid;
  assign S_AXI_BRESP   = s_r.bresp;
  assign S_AXI_ARREADY = s_r.arready;
  assign S_AXI_RVALID  = s_r.rvalid;
  assign S_AXI_RRESP   = s_r.rresp;
  assign S_AXI_RDATA   = {24'h000000, s_r.rdata};
  assign WAVE_OUT_A    = s_r.wave_a;
  assign WAVE_OUT_B    = s_r.wave_b;
  assign IRQ_REQ       = s_r.irq;

endmodule

// ### timer16_props.sv
/* Handshake checker for the timer register slave.
   Bound to timer16_core; sees only its bus ports. */
`timescale 1ns/1ps
module timer16_props (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  wr_answer_a: assert property (wr_take |-> ##[1:2] S_AXI_BVALID)
    else $error("write answer late");
  wr_refuse_a: assert property (wr_take |=> (!S_AXI_AWREADY && !S_AXI_WREADY)[*2])
    else $error("write ready not dropped");
  b_release_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> S_AXI_AWREADY && !S_AXI_BVALID)
    else $error("write ready not restored");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  rd_answer_a: assert property (rd_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  r_release_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> S_AXI_ARREADY && !S_AXI_RVALID)
    else $error("read ready not restored");
  byte_lane_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  one_write_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("second write accepted");
endmodule

// ### cpu_bus_model.sv
/* CPU-side byte master for the timer registers over AXI4-Lite.
   Assumes the slave shares clk; the bench calls its tasks. */
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  input  wire logic [1:0]  bresp,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic        rvalid,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  output logic             rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} <= '0;
  end
  // Slow answers too, so the slave must hold its response
  task automatic stall();
    repeat ($urandom_range(0, 2)) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw_p;
    bit w_p;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    while (aw_p || w_p) begin
      @(posedge clk);
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
        wdata <= ~{24'h0, d};
      end
    end
    stall();
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    stall();
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// ### tb.sv
/* Self-checking bench for timer16_core with a CPU bus model.
   Assumes timer16_props and cpu_bus_model are compiled first. */
`timescale 1ns/1ps
`include "timer16_defines.svh"
module tb;
  localparam int FILT = 4;
  logic        clk;
  logic        rst;
  logic        ext_pin;
  logic        cap_pin;
  logic        cmp_out;
  logic [7:0]  awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, wave_a, wave_b;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  irq;
  logic [15:0] v, w;
  int          c;
  int          fails;
  int          samples_checked;
  timer16_core #(.ADDR_W(8), .FILTER_LEN(FILT)) timer16_core_inst (
    .CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .EXT_COUNT_PIN(ext_pin),
    .CAPTURE_PIN(cap_pin), .COMPARATOR_OUTPUT(cmp_out), .WAVE_OUT_A(wave_a),
    .WAVE_OUT_B(wave_b), .IRQ_REQ(irq));
  cpu_bus_model cpu_bus_model_inst (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rdata(rdata), .rresp(rresp), .rready(rready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] join16(input logic [7:0] h, input logic [7:0] l);
    return {h, l};
  endfunction
  function automatic logic [3:0] irq_exp(input logic [3:0] f, input logic [3:0] m);
    return f & m;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s: %h not %h", $time, msg, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d, checks %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wb(input logic [7:0] a, input logic [7:0] x);
    cpu_bus_model_inst.wr(a, x, r);
    chk(r, `RESP_OKAY, "write resp");
  endtask
  task automatic rb(input logic [7:0] a, output logic [7:0] x);
    cpu_bus_model_inst.rd(a, x, r);
    chk(r, `RESP_OKAY, "read resp");
  endtask
  task automatic wr16(input logic [7:0] lo, input logic [15:0] x);
    wb(lo + 8'h04, x[15:8]);
    wb(lo, x[7:0]);
  endtask
  task automatic rd16(input logic [7:0] lo, output logic [15:0] x);
    rb(lo, x[7:0]);
    rb(lo + 8'h04, x[15:8]);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask
  initial begin
    {rst, ext_pin, cap_pin, cmp_out, fails, samples_checked} = {4'h8, 64'h0};
    void'($urandom(32'h419a6aeb));
    do_reset();
    for (int i = 0; i < 13; i++) begin
      rb(8'(i * 4), d);
      chk(d, 16'h0, "reset value");
    end
    repeat (4) begin
      v = 16'($urandom);
      wb(`OFF_CTL_A, v[7:0] & 8'hf3);
      wb(`OFF_CTL_B, v[15:8] & 8'hd8);
      rb(`OFF_CTL_A, d);
      chk(d, v[7:0] & 8'hf3, "control a");
      rb(`OFF_CTL_B, d);
      chk(d, v[15:8] & 8'hd8, "control b");
    end
    v = 16'($urandom);
    wr16(`OFF_COUNT_LO, v);
    rd16(`OFF_COUNT_LO, w);
    chk(w, v, "count wide");
    wb(`OFF_COUNT_HI, v[15:8]);
    wb(`OFF_CMPB_HI, v[7:0]);
    wb(`OFF_COUNT_LO, 8'h5a);
    rd16(`OFF_COUNT_LO, w);
    chk(w, join16(v[7:0], 8'h5a), "shared latch");
    w = 16'($urandom);
    wr16(`OFF_CMPA_LO, w);
    rb(`OFF_COUNT_LO, d);
    rb(`OFF_CMPA_LO, d);
    chk(d, w[7:0], "compare low");
    rb(`OFF_CMPA_HI, d);
    chk(d, w[15:8], "compare high");
    rb(`OFF_COUNT_HI, d);
    chk(d, v[7:0], "latch kept");
    cpu_bus_model_inst.wr(8'h34, 8'hff, r);
    chk(r, `RESP_SLVERR, "unmapped write");
    cpu_bus_model_inst.rd(8'h3c, d, r);
    chk({r, d}, {`RESP_SLVERR, 8'h0}, "unmapped read");
    // Fresh reset so the wave output starts from a known level
    do_reset();
    c = $urandom_range(16, 80);
    wb(`OFF_CTL_A, 8'h40);
    wr16(`OFF_CMPA_LO, 16'(c));
    wr16(`OFF_COUNT_LO, 16'h0);
    wb(`OFF_CTL_B, {5'h0, `CS_DIV1});
    repeat (c + 16) @(posedge clk);
    wb(`OFF_CTL_B, 8'h00);
    chk({wave_b, wave_a}, 16'h1, "wave toggle");
    rb(`OFF_FLAGS, d);
    chk(d & 8'h02, 16'h2, "match flag");
    chk(irq, 16'h0, "masked request");
    rd16(`OFF_COUNT_LO, v);
    rd16(`OFF_COUNT_LO, w);
    chk(w, v, "stopped count");
    chk(16'(v > 16'(c)), 16'h1, "count ran");
    wb(`OFF_MASK, 8'h02);
    // Request follows the mask one cycle late; look mid-cycle
    @(negedge clk);
    chk(irq, irq_exp(d[3:0], 4'h2), "request");
    wb(`OFF_FLAGS, 8'h02);
    rb(`OFF_FLAGS, d);
    chk({irq, d & 8'h02}, 16'h0, "flag clear");
    wr16(`OFF_COUNT_LO, 16'h0);
    wb(`OFF_CTL_A, 8'h01);
    wb(`OFF_CTL_B, {5'h0, `CS_DIV1});
    repeat (300) @(posedge clk);
    wb(`OFF_CTL_B, 8'h00);
    rd16(`OFF_COUNT_LO, v);
    chk(16'(v <= `TOP_8BIT), 16'h1, "fixed ceiling");
    rb(`OFF_FLAGS, d);
    chk(d & 8'h01, 16'h1, "ceiling wrap flag");
    v = 16'($urandom);
    wr16(`OFF_COUNT_LO, v);
    wb(`OFF_CTL_B, 8'hc0);
    cap_pin <= 1'b1;
    @(posedge clk);
    cap_pin <= 1'b0;
    repeat (FILT + 4) @(posedge clk);
    rb(`OFF_FLAGS, d);
    chk(d & 8'h08, 16'h0, "spike ignored");
    cap_pin <= 1'b1;
    repeat (FILT + 4) @(posedge clk);
    rb(`OFF_FLAGS, d);
    chk(d & 8'h08, 16'h8, "capture flag");
    rd16(`OFF_CAP_LO, w);
    chk(w, v, "capture value");
    wb(`OFF_CAP_SRC, 8'h01);
    repeat (FILT + 4) @(posedge clk);
    wb(`OFF_FLAGS, 8'h08);
    cmp_out <= 1'b1;
    repeat (FILT + 4) @(posedge clk);
    rb(`OFF_FLAGS, d);
    chk(d & 8'h08, 16'h8, "comparator capture");
    for (int k = 0; k < 2; k++) begin
      c = $urandom_range(1, 9);
      wr16(`OFF_COUNT_LO, 16'h0);
      wb(`OFF_CTL_B, {5'h0, (k == 0) ? `CS_EXT_FALL : `CS_EXT_RISE});
      repeat (c) begin
        ext_pin <= 1'b1;
        repeat (3) @(posedge clk);
        ext_pin <= 1'b0;
        repeat (3) @(posedge clk);
      end
      wb(`OFF_CTL_B, 8'h00);
      rd16(`OFF_COUNT_LO, v);
      chk(v, 16'(c), "pin count");
    end
    summarize();
  end
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
bind timer16_core timer16_props timer16_props_inst (
  .CORE_CLK(CORE_CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY));
